// ==== design/lrsh_pkg.sv ====
package lrsh_pkg;
  localparam logic [2:0] TYPE_IMM = 3'h0;
  localparam logic [2:0] TYPE_ISO = 3'h1;
  localparam logic [2:0] TYPE_PRI = 3'h2;
  localparam logic [2:0] TYPE_FAIR = 3'h3;
  localparam logic [2:0] TYPE_REGISTER_READ_REQUEST = 3'h4;
  localparam logic [2:0] TYPE_REGISTER_WRITE_REQUEST = 3'h5;
  localparam logic [2:0] TYPE_ACCEL = 3'h6;
  localparam logic [2:0] SPD_S100 = 3'h0;
  localparam logic [2:0] SPD_S200 = 3'h2;
  localparam logic [2:0] SPD_S400 = 3'h4;
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_STATUS = 2'h1;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  localparam logic [4:0] BIT_TYPE_LAST = 5'h03;
  localparam logic [4:0] BIT_BUS_SHORT = 5'h06;
  localparam logic [4:0] BIT_BUS_STOP = 5'h07;
  localparam logic [4:0] BIT_ACCEL_STOP = 5'h05;
  localparam logic [4:0] BIT_RD_STOP = 5'h08;
  localparam logic [4:0] BIT_WR_STOP = 5'h10;
  localparam logic [3:0] ACCEL_REG_ADDR = 4'h5;
  localparam int ACCEL_EN_POS = 1;
  localparam logic [7:0] PHYREG_RESET = 8'h00;
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_PHYREG_BASE = 12'h040;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SPEED_S100, SPEED_S200, SPEED_S400, SPEED_INVALID} lrsh_speed_t;
  typedef enum {ST_IDLE, ST_SHIFT} lrsh_state_t;

  typedef struct packed {
    logic imm;
    logic iso;
    logic pri;
    logic fair;
  } lrsh_pend_t;

  typedef struct packed {
    logic [2:0] speedCode;
    logic nullTx;
  } lrsh_bus_t;
endpackage

// ==== design/lrsh_handler.sv ====
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module lrsh_handler import lrsh_pkg::*; #(
  parameter int ADDR_W = 12,
  parameter int NREG = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Request line from the link
  input wire logic linkRequestLine,
  // Device-side interface activity
  input wire logic ifaceCtrlBit0,
  input wire logic ifaceCtrlBit1,
  input wire logic busResetEvt,
  input wire logic arbWonEvt,
  input wire logic statusRegDone,
  // Request state out to arbitration and status logic
  output lrsh_pend_t pendReq,
  output lrsh_bus_t busReqInfo,
  output lrsh_speed_t busSpeed,
  output logic grantNow,
  output logic accelActive,
  output logic readPending,
  output logic [3:0] readAddr,
  output logic [7:0] readData,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Request line synchroniser; no agreement filter, as the stream may change every clock
  logic lreqS1_r, lreqS2_r, lreqS3_r, lreqBit_r;
  logic lreqBit_nxt;

  always_comb begin
    lreqBit_nxt = lreqS3_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lreqS1_r <= 1'b0;
      lreqS2_r <= 1'b0;
      lreqS3_r <= 1'b0;
      lreqBit_r <= 1'b0;
    end else begin
      lreqS1_r <= linkRequestLine;
      lreqS2_r <= lreqS1_r;
      lreqS3_r <= lreqS2_r;
      lreqBit_r <= lreqBit_nxt;
    end
  end

  logic [1:0] ctl;
  assign ctl = {ifaceCtrlBit0, ifaceCtrlBit1};

  // Stream shifter
  lrsh_state_t state_r, state_nxt;
  logic [4:0] bitCnt_r, bitCnt_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [2:0] typ_r, typ_nxt;
  logic fpKill_r, fpKill_nxt;
  logic doneBus, doneRd, doneWr, doneAccel;
  logic [2:0] doneSpeed;

  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    sh_nxt = sh_r;
    typ_nxt = typ_r;
    fpKill_nxt = fpKill_r;
    doneBus = 1'b0;
    doneRd = 1'b0;
    doneWr = 1'b0;
    doneAccel = 1'b0;
    doneSpeed = sh_r[2:0];
    unique case (state_r)
      ST_IDLE: begin
        if (lreqBit_r) begin
          state_nxt = ST_SHIFT;
          bitCnt_nxt = 5'h01;
          sh_nxt = 16'h0000;
          fpKill_nxt = (ctl == CTL_RECEIVE);
        end
      end
      ST_SHIFT: begin
        sh_nxt = {sh_r[14:0], lreqBit_r};
        bitCnt_nxt = bitCnt_r + 5'h01;
        if (ctl == CTL_RECEIVE) begin
          fpKill_nxt = 1'b1;
        end
        if (bitCnt_r == BIT_TYPE_LAST) begin
          typ_nxt = sh_nxt[2:0];
          if (sh_nxt[2:0] == 3'h7) begin
            state_nxt = ST_IDLE;
          end
        end else if (typ_r <= TYPE_FAIR) begin
          // Stop bit may be absent when bit six is low
          if (bitCnt_r == BIT_BUS_SHORT && !lreqBit_r) begin
            doneBus = 1'b1;
            doneSpeed = sh_nxt[2:0];
            state_nxt = ST_IDLE;
          end else if (bitCnt_r == BIT_BUS_STOP) begin
            doneBus = 1'b1;
            doneSpeed = sh_nxt[3:1];
            state_nxt = ST_IDLE;
          end
        end else if (typ_r == TYPE_REGISTER_READ_REQUEST && bitCnt_r == BIT_RD_STOP) begin
          doneRd = 1'b1;
          state_nxt = ST_IDLE;
        end else if (typ_r == TYPE_REGISTER_WRITE_REQUEST && bitCnt_r == BIT_WR_STOP) begin
          doneWr = 1'b1;
          state_nxt = ST_IDLE;
        end else if (typ_r == TYPE_ACCEL && bitCnt_r == BIT_ACCEL_STOP) begin
          doneAccel = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      bitCnt_r <= 5'h00;
      sh_r <= 16'h0000;
      typ_r <= 3'h7;
      fpKill_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      sh_r <= sh_nxt;
      typ_r <= typ_nxt;
      fpKill_r <= fpKill_nxt;
    end
  end

  // Register file, shared by stream writes and the AXI port
  logic [7:0] phyReg_r [NREG];
  logic [7:0] phyReg_nxt [NREG];
  logic axiRegWe;
  logic [3:0] axiRegIdx;
  logic accelEnBit;
  assign accelEnBit = phyReg_r[ACCEL_REG_ADDR][ACCEL_EN_POS];

  // Stream write wins over a same-cycle AXI write to the same register
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_comb begin
        phyReg_nxt[gi] = phyReg_r[gi];
        if (doneWr && sh_nxt[12:9] == 4'(gi)) begin
          phyReg_nxt[gi] = sh_nxt[8:1];
        end else if (axiRegWe && axiRegIdx == 4'(gi) && wStrb_r[0]) begin
          phyReg_nxt[gi] = wData_r[7:0];
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          phyReg_r[gi] <= PHYREG_RESET;
        end else begin
          phyReg_r[gi] <= phyReg_nxt[gi];
        end
      end
    end
  endgenerate

  // Request bookkeeping
  lrsh_pend_t pend_r, pend_nxt;
  lrsh_bus_t bus_r, bus_nxt;
  lrsh_speed_t spd_r, spd_nxt;
  logic [1:0] ctlPrev_r;
  logic grant_r, grant_nxt;
  logic acceleration_control_request_r, acceleration_control_request_nxt;
  logic accelAct_r, accelAct_nxt;
  logic rdPend_r, rdPend_nxt;
  logic [3:0] rdAddr_r, rdAddr_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic busIdle;
  assign busIdle = !(pend_r.imm || pend_r.iso || pend_r.pri || pend_r.fair);

  always_comb begin
    pend_nxt = pend_r;
    bus_nxt = bus_r;
    spd_nxt = spd_r;
    acceleration_control_request_nxt = acceleration_control_request_r;
    rdPend_nxt = rdPend_r;
    rdAddr_nxt = rdAddr_r;
    grant_nxt = 1'b0;
    // Grant right at the end of reception, no arbitration wait
    if (pend_r.imm && ctlPrev_r == CTL_RECEIVE && ctl != CTL_RECEIVE) begin
      grant_nxt = 1'b1;
      pend_nxt.imm = 1'b0;
    end
    if (arbWonEvt) begin
      pend_nxt = '0;
    end
    if (ctl == CTL_RECEIVE) begin
      pend_nxt.pri = 1'b0;
      pend_nxt.fair = 1'b0;
    end
    if (doneBus && busIdle) begin
      if (typ_r == TYPE_IMM) begin
        pend_nxt.imm = 1'b1;
      end else if (typ_r == TYPE_ISO) begin
        pend_nxt.iso = 1'b1;
        if (accelEnBit) begin
          acceleration_control_request_nxt = 1'b1;
        end
      end else if (!fpKill_nxt) begin
        pend_nxt.pri = (typ_r == TYPE_PRI);
        pend_nxt.fair = (typ_r == TYPE_FAIR);
      end
      bus_nxt.speedCode = doneSpeed;
      unique case (doneSpeed)
        SPD_S100: spd_nxt = SPEED_S100;
        SPD_S200: spd_nxt = SPEED_S200;
        SPD_S400: spd_nxt = SPEED_S400;
        default: spd_nxt = SPEED_INVALID;
      endcase
      bus_nxt.nullTx = (spd_nxt == SPEED_INVALID);
    end
    if (busResetEvt) begin
      pend_nxt = '0;
      if (accelEnBit) begin
        acceleration_control_request_nxt = 1'b1;
      end
    end
    if (doneAccel) begin
      acceleration_control_request_nxt = sh_nxt[1];
    end
    // Bus reset leaves a pending read alone
    if (statusRegDone) begin
      rdPend_nxt = 1'b0;
    end
    if (doneRd && !rdPend_r) begin
      rdPend_nxt = 1'b1;
      rdAddr_nxt = sh_nxt[4:1];
    end
    rdData_nxt = phyReg_nxt[rdAddr_nxt];
    accelAct_nxt = phyReg_nxt[ACCEL_REG_ADDR][ACCEL_EN_POS] && acceleration_control_request_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_r <= '0;
      bus_r <= '0;
      spd_r <= SPEED_S100;
      ctlPrev_r <= CTL_IDLE;
      grant_r <= 1'b0;
      acceleration_control_request_r <= 1'b1;
      accelAct_r <= 1'b0;
      rdPend_r <= 1'b0;
      rdAddr_r <= 4'h0;
      rdData_r <= 8'h00;
    end else begin
      pend_r <= pend_nxt;
      bus_r <= bus_nxt;
      spd_r <= spd_nxt;
      ctlPrev_r <= ctl;
      grant_r <= grant_nxt;
      acceleration_control_request_r <= acceleration_control_request_nxt;
      accelAct_r <= accelAct_nxt;
      rdPend_r <= rdPend_nxt;
      rdAddr_r <= rdAddr_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign pendReq = pend_r;
  assign busReqInfo = bus_r;
  assign busSpeed = spd_r;
  assign grantNow = grant_r;
  assign accelActive = accelAct_r;
  assign readPending = rdPend_r;
  assign readAddr = rdAddr_r;
  assign readData = rdData_r;

  // AXI4-Lite slave; address and data may arrive in either order
  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rData_r, rData_nxt;
  logic [3:0] wStrb_r, wStrb_nxt;
  logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic awHit, arHit;
  assign awHit = awAddr_r >= ADDR_W'(ADDR_PHYREG_BASE) && awAddr_r < ADDR_W'(ADDR_PHYREG_BASE + 12'(NREG * 4));
  assign arHit = s_axi_araddr >= ADDR_W'(ADDR_PHYREG_BASE) &&
                 s_axi_araddr < ADDR_W'(ADDR_PHYREG_BASE + 12'(NREG * 4));
  assign axiRegWe = awHave_r && wHave_r && !bv_r && awHit;
  assign axiRegIdx = 4'((awAddr_r - ADDR_W'(ADDR_PHYREG_BASE)) >> 2);

  always_comb begin
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bv_nxt = bv_r;
    bResp_nxt = bResp_r;
    rv_nxt = rv_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (s_axi_awvalid && !awHave_r) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHave_r) begin
      wHave_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    if (awHave_r && wHave_r && !bv_r) begin
      bv_nxt = 1'b1;
      bResp_nxt = (awHit || awAddr_r == ADDR_W'(ADDR_STATUS)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
    end
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rv_r) begin
      rv_nxt = 1'b1;
      rResp_nxt = RESP_OKAY;
      rData_nxt = 32'h00000000;
      if (s_axi_araddr == ADDR_W'(ADDR_STATUS)) begin
        rData_nxt = {17'h00000, acceleration_control_request_r, accelAct_r, rdAddr_r, rdPend_r, bus_r.nullTx,
                     bus_r.speedCode, pend_r.fair, pend_r.pri, pend_r.iso, pend_r.imm};
      end else if (arHit) begin
        rData_nxt = {24'h000000, phyReg_r[4'((s_axi_araddr - ADDR_W'(ADDR_PHYREG_BASE)) >> 2)]};
      end else begin
        rResp_nxt = RESP_SLVERR;
      end
    end
  end

  // Write data lands through the shared register file above
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      bv_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      rv_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= RESP_OKAY;
    end else begin
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bv_r <= bv_nxt;
      bResp_r <= bResp_nxt;
      rv_r <= rv_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
    end
  end

  // Ready is high while the holding slot is empty
  assign s_axi_awready = !awHave_r;
  assign s_axi_wready = !wHave_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
endmodule

// ==== test/lrsh_link_model.sv ====
`timescale 1ns/10ps
module lrsh_link_model (
  // Clock
  input wire logic ref_clk,
  // Request line
  output logic linkRequestLine
);
  initial linkRequestLine = 1'h0;

  // Streams go out MSB first; the line drops low after the last bit
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      linkRequestLine <= bits[i];
    end
    @(posedge ref_clk);
    linkRequestLine <= 1'h0;
  endtask
endmodule

// ==== test/lrsh_handler_props.sv ====
`timescale 1ns/10ps
module lrsh_handler_chk import lrsh_pkg::*; (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // Device side
  input logic ifaceCtrlBit0,
  input logic ifaceCtrlBit1,
  input logic busResetEvt,
  input logic arbWonEvt,
  input logic statusRegDone,
  // Request state
  input lrsh_pend_t pendReq,
  input lrsh_bus_t busReqInfo,
  input lrsh_speed_t busSpeed,
  input logic grantNow,
  input logic readPending,
  input logic [3:0] readAddr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic rcv;
  assign rcv = {ifaceCtrlBit0, ifaceCtrlBit1} == CTL_RECEIVE;
  property p_rcv_clr;
    rcv |=> !pendReq.pri && !pendReq.fair;
  endproperty
  a_rcv_clr: assert property (p_rcv_clr) else $error("fair or priority kept under receive");
  property p_grant;
    !rcv && $past(rcv) && pendReq.imm |-> ##[0:2] grantNow;
  endproperty
  a_grant: assert property (p_grant) else $error("no grant after receive end");
  property p_grant_pulse;
    grantNow |-> !pendReq.imm ##1 !grantNow;
  endproperty
  a_grant_pulse: assert property (p_grant_pulse) else $error("grant not a clean pulse");
  property p_iso_keep;
    pendReq.iso && !arbWonEvt && !busResetEvt |=> pendReq.iso;
  endproperty
  a_iso_keep: assert property (p_iso_keep) else $error("iso request dropped early");
  property p_bus_reset;
    busResetEvt |=> pendReq == 4'h0;
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("bus reset left a request");
  property p_one;
    $countones(pendReq) <= 1;
  endproperty
  a_one: assert property (p_one) else $error("two bus requests pending");
  property p_read_keep;
    readPending && !statusRegDone |=> readPending && $stable(readAddr);
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("pending read lost or changed");
  property p_read_done;
    statusRegDone && readPending |=> !readPending;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read still pending after delivery");
  property p_speed;
    busSpeed == (busReqInfo.speedCode == SPD_S100 ? SPEED_S100 : busReqInfo.speedCode == SPD_S200 ? SPEED_S200 :
      busReqInfo.speedCode == SPD_S400 ? SPEED_S400 : SPEED_INVALID);
  endproperty
  a_speed: assert property (p_speed) else $error("speed decode wrong");
  property p_null;
    busReqInfo.nullTx == (busSpeed == SPEED_INVALID);
  endproperty
  a_null: assert property (p_null) else $error("null packet flag wrong");
  c_grant: cover property (grantNow);
  c_read: cover property ($rose(readPending));
  c_null: cover property (busReqInfo.nullTx);
endmodule

bind lrsh_handler lrsh_handler_chk u_chk (.ref_clk(ref_clk), .rst(rst), .ifaceCtrlBit0(ifaceCtrlBit0),
  .ifaceCtrlBit1(ifaceCtrlBit1), .busResetEvt(busResetEvt), .arbWonEvt(arbWonEvt), .statusRegDone(statusRegDone),
  .pendReq(pendReq), .busReqInfo(busReqInfo), .busSpeed(busSpeed), .grantNow(grantNow),
  .readPending(readPending), .readAddr(readAddr));

// ==== test/testbench.sv ====
`timescale 1ns/10ps
module testbench import lrsh_pkg::*;;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] ctl = CTL_IDLE;
  logic [2:0] evt = 3'h0;
  logic link_request_line;
  lrsh_pend_t pendReq;
  lrsh_bus_t busReqInfo;
  lrsh_speed_t busSpeed;
  logic grantNow, accelActive, readPending;
  logic [3:0] readAddr;
  logic [7:0] readData;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, checked = 0, cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  lrsh_handler DUT (.ref_clk(ref_clk), .rst(rst), .linkRequestLine(link_request_line), .ifaceCtrlBit0(ctl[1]),
    .ifaceCtrlBit1(ctl[0]), .busResetEvt(evt[2]), .arbWonEvt(evt[1]), .statusRegDone(evt[0]), .pendReq(pendReq),
    .busReqInfo(busReqInfo), .busSpeed(busSpeed), .grantNow(grantNow), .accelActive(accelActive),
    .readPending(readPending), .readAddr(readAddr), .readData(readData), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  lrsh_link_model LNK (.ref_clk(ref_clk), .linkRequestLine(link_request_line));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Sample a little after the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic req(input logic [31:0] bits, input int n);
    LNK.send(bits, n);
    tick(6);
  endtask
  function automatic logic [31:0] bus(input logic [2:0] t, input logic [2:0] s);
    return {24'h0, 1'h1, t, s, 1'h0};
  endfunction
  task automatic setctl(input logic [1:0] v);
    @(posedge ref_clk);
    ctl <= v;
  endtask
  task automatic ev(input logic [2:0] v);
    @(posedge ref_clk);
    evt <= v;
    @(posedge ref_clk);
    evt <= 3'h0;
    tick(1);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    tick(1);
    chk(pendReq, 32'h0);
    axr(12'h000, d, r);
    chk(d, 32'h4000);
    axr(12'h800, d, r);
    chk(r, RESP_SLVERR);
    axw(12'h800, 32'h1, r);
    chk(r, RESP_SLVERR);
    $display("test reset done");
    req({15'h0, 1'h1, TYPE_REGISTER_WRITE_REQUEST, 4'h3, 8'ha5, 1'h0}, 17);
    axr(12'h04c, d, r);
    chk(d, 32'ha5);
    req({8'h0, 1'h1, TYPE_FAIR, SPD_S100, 1'h1, TYPE_REGISTER_WRITE_REQUEST, 4'h2, 8'h3c, 1'h0}, 24);
    chk(pendReq, 32'h1);
    axr(12'h048, d, r);
    chk(d, 32'h3c);
    ev(3'h2);
    $display("test register write done");
    for (int s = 0; s < 8; s++) begin
      req(bus(3'(s % 4), 3'(s)), 8);
      chk(pendReq, 4'h8 >> (s % 4));
      chk(busReqInfo, {3'(s), s != 0 && s != 2 && s != 4});
      chk(busSpeed, s == 0 ? SPEED_S100 : s == 2 ? SPEED_S200 : s == 4 ? SPEED_S400 : SPEED_INVALID);
      ev(3'h2);
      chk(pendReq, 32'h0);
    end
    $display("test speeds done");
    req(bus(TYPE_ISO, SPD_S200), 8);
    req(bus(TYPE_FAIR, SPD_S400), 8);
    chk(pendReq, 32'h4);
    chk(busReqInfo, {SPD_S200, 1'h0});
    setctl(CTL_RECEIVE);
    tick(2);
    chk(pendReq, 32'h4);
    setctl(CTL_IDLE);
    ev(3'h2);
    req(bus(TYPE_FAIR, SPD_S100), 8);
    setctl(CTL_RECEIVE);
    tick(2);
    chk(pendReq, 32'h0);
    req(bus(TYPE_PRI, SPD_S100), 8);
    chk(pendReq, 32'h0);
    setctl(CTL_IDLE);
    req(bus(TYPE_PRI, SPD_S100), 8);
    chk(pendReq, 32'h2);
    ev(3'h4);
    chk(pendReq, 32'h0);
    // Receive only while the request is still being shifted in
    fork
      req(bus(TYPE_PRI, SPD_S100), 8);
      begin
        repeat (6) @(posedge ref_clk);
        setctl(CTL_RECEIVE);
        setctl(CTL_IDLE);
      end
    join
    chk(pendReq, 32'h0);
    $display("test pending done");
    setctl(CTL_RECEIVE);
    req(bus(TYPE_IMM, SPD_S400), 8);
    chk(pendReq, 32'h8);
    setctl(CTL_IDLE);
    tick(1);
    chk(grantNow, 32'h1);
    chk(pendReq, 32'h0);
    tick(1);
    chk(grantNow, 32'h0);
    $display("test grant done");
    req({23'h0, 1'h1, TYPE_REGISTER_READ_REQUEST, 4'h3, 1'h0}, 9);
    chk({readPending, readAddr, readData}, {1'h1, 4'h3, 8'ha5});
    req({23'h0, 1'h1, TYPE_REGISTER_READ_REQUEST, 4'h2, 1'h0}, 9);
    chk(readAddr, 32'h3);
    ev(3'h4);
    chk(readPending, 32'h1);
    ev(3'h1);
    chk(readPending, 32'h0);
    req({23'h0, 1'h1, TYPE_REGISTER_READ_REQUEST, 4'h2, 1'h0}, 9);
    chk({readPending, readAddr, readData}, {1'h1, 4'h2, 8'h3c});
    ev(3'h1);
    req({28'h0, 1'h1, 3'h7}, 4);
    chk({pendReq, readPending}, 32'h0);
    $display("test read done");
    axw(12'h054, 32'h2, r);
    chk(r, RESP_OKAY);
    tick(1);
    chk(accelActive, 32'h1);
    req({26'h0, 1'h1, TYPE_ACCEL, 1'h0, 1'h0}, 6);
    chk(accelActive, 32'h0);
    req({26'h0, 1'h1, TYPE_ACCEL, 1'h1, 1'h0}, 6);
    chk(accelActive, 32'h1);
    req({26'h0, 1'h1, TYPE_ACCEL, 1'h0, 1'h0}, 6);
    ev(3'h4);
    chk(accelActive, 32'h1);
    req({26'h0, 1'h1, TYPE_ACCEL, 1'h0, 1'h0}, 6);
    req(bus(TYPE_ISO, SPD_S100), 8);
    chk(accelActive, 32'h1);
    ev(3'h2);
    axw(12'h054, 32'h0, r);
    req({26'h0, 1'h1, TYPE_ACCEL, 1'h1, 1'h0}, 6);
    chk(accelActive, 32'h0);
    @(posedge ref_clk);
    s_axi_wstrb <= 4'he;
    axw(12'h048, 32'hff, r);
    s_axi_wstrb <= 4'hf;
    chk(r, RESP_OKAY);
    axr(12'h048, d, r);
    chk(d, 32'h3c);
    $display("test acceleration done");
    final_report();
  end
endmodule
